// File: rtl/vgcr_pkg.sv
// Package with register map, field layout, reset values and carrier types of the genlock control registers.
package vgcr_pkg;

  localparam logic [7:0] BLANK_LEVEL_MEASURE_OFS   = 8'h06;
  localparam logic [7:0] RESERVED_SLOT_SEVEN_OFS   = 8'h07;
  localparam logic [7:0] STANDARD_RATE_CONTROL_OFS = 8'h08;
  localparam logic [7:0] SYNC_POSITION_OFFSET_OFS  = 8'h09;

  localparam int STD_MSB    = 7;
  localparam int STD_LSB    = 6;
  localparam int RATE_MSB   = 5;
  localparam int RATE_LSB   = 4;
  localparam int FREE_BIT   = 3;
  localparam int SUPP_BIT   = 2;
  localparam int CLAMP_BIT  = 1;
  localparam int SRST_BIT   = 0;

  localparam logic [1:0] STD_525      = 2'h0;
  localparam logic [1:0] STD_PAL_M    = 2'h1;
  localparam logic [1:0] STD_PAL_BGHI = 2'h2;
  localparam logic [1:0] STD_PAL_N    = 2'h3;
  localparam logic [1:0] RATE_12M27   = 2'h0;
  localparam logic [1:0] RATE_13M5    = 2'h1;
  localparam logic [1:0] RATE_14M75   = 2'h2;
  localparam logic [1:0] RATE_15M0    = 2'h3;

  localparam logic [1:0] STD_RESET    = STD_525;
  localparam logic [1:0] RATE_RESET   = RATE_12M27;
  localparam logic       FREE_RESET   = 1'h0;
  localparam logic       SUPP_RESET   = 1'h0;
  localparam logic       CLAMP_RESET  = 1'h1;
  localparam logic [7:0] OFFSET_RESET = 8'h80;
  localparam logic [7:0] BLANK_RESET  = 8'h00;

  // Nominal blank readings for a clean input, for reference by software.
  localparam logic [7:0] BLANK_NOMINAL_525 = 8'h3C;
  localparam logic [7:0] BLANK_NOMINAL_625 = 8'h40;

  // Lead-lag code that, with a half-pixel subpixel setting, aligns sync out to the input falling sync edge.
  localparam logic [7:0] OFFSET_ALIGN_CODE = 8'h79;

  typedef struct packed {
    logic [1:0] video_standard_select;
    logic [1:0] sample_rate_select;
    logic       free_run;
    logic       reference_data_suppress;
    logic       digital_porch_clamp_enable;
  } vgcr_ctrl_s;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } vgcr_req_s;

endpackage

// File: rtl/vgcr_regs.sv
// Control and status registers at offsets 06h to 09h of the genlocking video digitizer.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Blank level captured from filtered converter during back porch.
// - Nominal blank about 60 (525) or 64 (625).
// - Bits 7:6 select the video standard.
// - Bits 5:4 select the pixel sample rate.
// - Top two rate codes only on extended variant.
// - Odd standard/rate combinations lose subcarrier validity.
// - Free-run low: syncs follow the locked video timing.
// - Free-run high: hsync counted down from free clock.
// - Suppress low: reference data inserted during hsync.
// - Suppress high: bus carries only video samples.
// - Bit 1 enables the vertically filtered porch clamp.
// - Soft reset bit returns high by itself.
// - Soft reset bit always reads as one.
// - Lead-lag register, one-pixel steps, resets to 80h.
// - Lower lead-lag advances syncs, higher delays them.
// - Code 79h plus half pixel aligns sync edge.
// - Subpixel offset is 5-bit fraction, outside this block.
module vgcr_regs #(
  parameter bit          EXTENDED_RATES = 1'b0,
  parameter int          FREE_LINE_CLKS = 1000,
  parameter int          HSYNC_CLKS     = 64
) (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst_b,
  input  wire vgcr_pkg::vgcr_req_s  i_req,
  input  wire logic [7:0]           i_adc_lpf_sample,
  input  wire logic                 i_back_porch,
  input  wire logic [7:0]           i_video_sample,
  input  wire logic [7:0]           i_genlock_reference_data,
  input  wire logic                 i_locked_hsync,
  input  wire logic                 i_locked_vsync,
  output logic [7:0]                o_reg_rdata,
  output logic                      o_reg_rvalid,
  output vgcr_pkg::vgcr_ctrl_s      o_ctrl,
  output logic [7:0]                o_sync_position_offset,
  output logic                      o_soft_reset,
  output logic                      o_subcarrier_valid,
  output logic                      o_horizontal_sync_out,
  output logic                      o_vertical_sync_out,
  output logic [7:0]                o_composite_data_bus
);

  // The 12-bit down-counter bounds the line length, and the sync pulse must end inside the line.
  if (FREE_LINE_CLKS < 2 || FREE_LINE_CLKS > 4095 || HSYNC_CLKS < 1 || HSYNC_CLKS >= FREE_LINE_CLKS)
  begin
    $error("vgcr_regs: free-run line length or sync width out of range.");
  end

  localparam logic [11:0] LINE_LAST = 12'(FREE_LINE_CLKS - 1);
  localparam logic [11:0] SYNC_END  = 12'(HSYNC_CLKS);

  typedef struct packed {
    vgcr_pkg::vgcr_ctrl_s ctrl;
    logic [7:0]           offset;
    logic [7:0]           blank_level;
    logic [7:0]           rdata;
    logic                 rvalid;
    logic                 srst;
    logic                 sub_valid;
    logic [11:0]          line_cnt;
    logic                 hsync;
    logic                 vsync;
    logic [7:0]           composite_data_bus;
  } vgcr_state_s;

  vgcr_state_s state;
  vgcr_state_s next_state;

  logic [7:0] ctrl_read;
  logic       ctrl_write;

  always_comb
  begin
    ctrl_read  = {state.ctrl.video_standard_select, state.ctrl.sample_rate_select, state.ctrl.free_run,
                  state.ctrl.reference_data_suppress, state.ctrl.digital_porch_clamp_enable, 1'h1};
    ctrl_write = i_req.wr && i_req.addr == vgcr_pkg::STANDARD_RATE_CONTROL_OFS;
    next_state = state;
    next_state.rvalid = i_req.rd;
    next_state.srst   = 1'h0;
    if (i_req.rd)
    begin
      unique case (i_req.addr)
        vgcr_pkg::BLANK_LEVEL_MEASURE_OFS:   next_state.rdata = state.blank_level;
        vgcr_pkg::STANDARD_RATE_CONTROL_OFS: next_state.rdata = ctrl_read;
        vgcr_pkg::SYNC_POSITION_OFFSET_OFS:  next_state.rdata = state.offset;
        default:                             next_state.rdata = 8'h00;
      endcase
    end
    if (ctrl_write)
    begin
      next_state.ctrl.video_standard_select = i_req.wdata[vgcr_pkg::STD_MSB:vgcr_pkg::STD_LSB];
      next_state.ctrl.sample_rate_select    = i_req.wdata[vgcr_pkg::RATE_MSB:vgcr_pkg::RATE_LSB];
      // A base part keeps the upper rate bit clear, so codes 10 and 11 fold onto 00 and 01.
      if (!EXTENDED_RATES)
      begin
        next_state.ctrl.sample_rate_select[1] = 1'h0;
      end
      next_state.ctrl.free_run                   = i_req.wdata[vgcr_pkg::FREE_BIT];
      next_state.ctrl.reference_data_suppress    = i_req.wdata[vgcr_pkg::SUPP_BIT];
      next_state.ctrl.digital_porch_clamp_enable = i_req.wdata[vgcr_pkg::CLAMP_BIT];
      next_state.srst = !i_req.wdata[vgcr_pkg::SRST_BIT];
    end
    if (i_req.wr && i_req.addr == vgcr_pkg::SYNC_POSITION_OFFSET_OFS)
    begin
      next_state.offset = i_req.wdata;
    end
    // Standard and rate codes 0x1x and 1x00 give no usable subcarrier.
    next_state.sub_valid = !(!next_state.ctrl.video_standard_select[1] && next_state.ctrl.sample_rate_select[1])
                        && !(next_state.ctrl.video_standard_select[1]
                             && next_state.ctrl.sample_rate_select == vgcr_pkg::RATE_12M27);
    if (i_back_porch)
    begin
      next_state.blank_level = i_adc_lpf_sample;
    end
    next_state.line_cnt = (state.line_cnt == 12'h000) ? LINE_LAST : state.line_cnt - 12'h001;
    next_state.hsync = state.ctrl.free_run ? (state.line_cnt < SYNC_END) : i_locked_hsync;
    next_state.vsync = i_locked_vsync;
    next_state.composite_data_bus  = (!state.ctrl.reference_data_suppress && i_locked_hsync) ? i_genlock_reference_data
                                                                            : i_video_sample;
    // Soft reset clears the internal state and leaves the host control bits alone.
    if (state.srst)
    begin
      next_state.blank_level = vgcr_pkg::BLANK_RESET;
      next_state.line_cnt    = LINE_LAST;
      next_state.hsync       = 1'h0;
      next_state.vsync       = 1'h0;
      next_state.composite_data_bus        = 8'h00;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state                                  <= '0;
      state.ctrl.video_standard_select       <= vgcr_pkg::STD_RESET;
      state.ctrl.sample_rate_select          <= vgcr_pkg::RATE_RESET;
      state.ctrl.free_run                    <= vgcr_pkg::FREE_RESET;
      state.ctrl.reference_data_suppress     <= vgcr_pkg::SUPP_RESET;
      state.ctrl.digital_porch_clamp_enable  <= vgcr_pkg::CLAMP_RESET;
      state.offset                           <= vgcr_pkg::OFFSET_RESET;
      state.blank_level                      <= vgcr_pkg::BLANK_RESET;
      state.sub_valid                        <= 1'h1;
      state.line_cnt                         <= LINE_LAST;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign o_reg_rdata            = state.rdata;
  assign o_reg_rvalid           = state.rvalid;
  assign o_ctrl                 = state.ctrl;
  // The timing core applies this whole-pixel offset together with its own subpixel fraction.
  assign o_sync_position_offset = state.offset;
  assign o_soft_reset           = state.srst;
  assign o_subcarrier_valid     = state.sub_valid;
  assign o_horizontal_sync_out  = state.hsync;
  assign o_vertical_sync_out    = state.vsync;
  assign o_composite_data_bus   = state.composite_data_bus;

  property p_srst_one_shot;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (i_req.wr && i_req.addr == vgcr_pkg::STANDARD_RATE_CONTROL_OFS && !i_req.wdata[0])
      |=> o_soft_reset ##1 !o_soft_reset || $past(i_req.wr);
  endproperty
  a_srst_one_shot: assert property (p_srst_one_shot) else $error("Soft reset is not a single pulse.");

  property p_srst_reads_one;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (i_req.rd && i_req.addr == vgcr_pkg::STANDARD_RATE_CONTROL_OFS) |=> o_reg_rvalid && o_reg_rdata[0];
  endproperty
  a_srst_reads_one: assert property (p_srst_reads_one) else $error("Soft reset bit read as zero.");

  property p_reserved_zero;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (i_req.rd && i_req.addr == vgcr_pkg::RESERVED_SLOT_SEVEN_OFS) |=> o_reg_rdata == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved slot read nonzero.");

  property p_srst_keeps_ctrl;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    o_soft_reset |=> $stable(o_ctrl) && $stable(o_sync_position_offset) || $past(i_req.wr);
  endproperty
  a_srst_keeps_ctrl: assert property (p_srst_keeps_ctrl) else $error("Soft reset altered control bits.");

  property p_rate_variant;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    !EXTENDED_RATES |-> !o_ctrl.sample_rate_select[1];
  endproperty
  a_rate_variant: assert property (p_rate_variant) else $error("Extended rate code on base variant.");

  property p_ref_insert;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (!o_ctrl.reference_data_suppress && i_locked_hsync && !o_soft_reset)
      |=> o_composite_data_bus == $past(i_genlock_reference_data);
  endproperty
  a_ref_insert: assert property (p_ref_insert) else $error("Reference data missing in sync pulse.");

  property p_ref_suppress;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (o_ctrl.reference_data_suppress && !o_soft_reset) |=> o_composite_data_bus == $past(i_video_sample);
  endproperty
  a_ref_suppress: assert property (p_ref_suppress) else $error("Bus not carrying plain video.");

  property p_blank_capture;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (i_back_porch && !o_soft_reset) |=> state.blank_level == $past(i_adc_lpf_sample);
  endproperty
  a_blank_capture: assert property (p_blank_capture) else $error("Blank level not captured.");

  property p_genlock_sync;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (!o_ctrl.free_run && !o_soft_reset) |=> o_horizontal_sync_out == $past(i_locked_hsync);
  endproperty
  a_genlock_sync: assert property (p_genlock_sync) else $error("Sync not following locked timing.");

  property p_free_sync_period;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (o_ctrl.free_run && !o_soft_reset && state.line_cnt == 12'h000) |=> o_horizontal_sync_out;
  endproperty
  a_free_sync_period: assert property (p_free_sync_period) else $error("Free-run sync missing at wrap.");

  property p_srst_clears;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    o_soft_reset |=> state.blank_level == vgcr_pkg::BLANK_RESET && state.line_cnt == LINE_LAST
      && !o_horizontal_sync_out && !o_vertical_sync_out && o_composite_data_bus == 8'h00;
  endproperty
  a_srst_clears: assert property (p_srst_clears) else $error("Soft reset left internal state.");

  property p_srst_needs_write;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    !(ctrl_write && !i_req.wdata[vgcr_pkg::SRST_BIT]) |=> !o_soft_reset;
  endproperty
  a_srst_needs_write: assert property (p_srst_needs_write) else $error("Soft reset without a write.");

  property p_blank_read;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (i_req.rd && i_req.addr == vgcr_pkg::BLANK_LEVEL_MEASURE_OFS) |=> o_reg_rdata == $past(state.blank_level);
  endproperty
  a_blank_read: assert property (p_blank_read) else $error("Blank level read back wrong.");

  property p_offset_read;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (i_req.rd && i_req.addr == vgcr_pkg::SYNC_POSITION_OFFSET_OFS)
      |=> o_reg_rdata == $past(o_sync_position_offset);
  endproperty
  a_offset_read: assert property (p_offset_read) else $error("Lead-lag read back wrong.");

  property p_offset_write;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (i_req.wr && i_req.addr == vgcr_pkg::SYNC_POSITION_OFFSET_OFS)
      |=> o_sync_position_offset == $past(i_req.wdata);
  endproperty
  a_offset_write: assert property (p_offset_write) else $error("Lead-lag write lost.");

  property p_std_write;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    ctrl_write |=> o_ctrl.video_standard_select == $past(i_req.wdata[vgcr_pkg::STD_MSB:vgcr_pkg::STD_LSB]);
  endproperty
  a_std_write: assert property (p_std_write) else $error("Standard field write lost.");

  property p_rate_write;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    ctrl_write |=> o_ctrl.sample_rate_select[0] == $past(i_req.wdata[vgcr_pkg::RATE_LSB]);
  endproperty
  a_rate_write: assert property (p_rate_write) else $error("Rate field write lost.");

  property p_clamp_write;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    ctrl_write |=> o_ctrl.digital_porch_clamp_enable == $past(i_req.wdata[vgcr_pkg::CLAMP_BIT]);
  endproperty
  a_clamp_write: assert property (p_clamp_write) else $error("Clamp enable write lost.");

  property p_ctrl_hold;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    !ctrl_write |=> $stable(o_ctrl);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("Control bits changed without a write.");

  property p_offset_hold;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    !(i_req.wr && i_req.addr == vgcr_pkg::SYNC_POSITION_OFFSET_OFS) |=> $stable(o_sync_position_offset);
  endproperty
  a_offset_hold: assert property (p_offset_hold) else $error("Lead-lag changed without a write.");

  property p_plain_video;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (!o_soft_reset && !i_locked_hsync) |=> o_composite_data_bus == $past(i_video_sample);
  endproperty
  a_plain_video: assert property (p_plain_video) else $error("Bus not carrying video outside sync.");

  property p_vsync_follow;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    !o_soft_reset |=> o_vertical_sync_out == $past(i_locked_vsync);
  endproperty
  a_vsync_follow: assert property (p_vsync_follow) else $error("Vertical sync not following timing.");

endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench for the genlock control register block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                  i_core_clk = 1'b0;
  logic                  i_rst_b    = 1'b0;
  vgcr_pkg::vgcr_req_s   req        = '0;
  logic [7:0]            adc = 8'h00, vid = 8'h00, grd = 8'h00;
  logic                  bp = 1'b0, lhs = 1'b0, lvs = 1'b0;
  logic [7:0]            rdata, offs, bus;
  logic                  rvalid, srst, scv, hs, vs, scv_x;
  vgcr_pkg::vgcr_ctrl_s  ctrl, ctrl_x;
  int                    n_fail = 0, comparisons = 0, seed = 32'hb6a5, k, cnt;
  logic [7:0]            v, b;
  always #50 i_core_clk = ~i_core_clk;
  vgcr_regs #(.EXTENDED_RATES(1'b0), .FREE_LINE_CLKS(20), .HSYNC_CLKS(4)) DUT (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_req(req), .i_adc_lpf_sample(adc),
    .i_back_porch(bp), .i_video_sample(vid), .i_genlock_reference_data(grd),
    .i_locked_hsync(lhs), .i_locked_vsync(lvs), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .o_ctrl(ctrl), .o_sync_position_offset(offs), .o_soft_reset(srst),
    .o_subcarrier_valid(scv), .o_horizontal_sync_out(hs), .o_vertical_sync_out(vs),
    .o_composite_data_bus(bus));
  // Extended-rate variant sharing the same stimulus, for the upper rate codes.
  vgcr_regs #(.EXTENDED_RATES(1'b1), .FREE_LINE_CLKS(20), .HSYNC_CLKS(4)) DUT_EXT (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_req(req), .i_adc_lpf_sample(adc),
    .i_back_porch(bp), .i_video_sample(vid), .i_genlock_reference_data(grd),
    .i_locked_hsync(lhs), .i_locked_vsync(lvs), .o_reg_rdata(), .o_reg_rvalid(),
    .o_ctrl(ctrl_x), .o_sync_position_offset(), .o_soft_reset(),
    .o_subcarrier_valid(scv_x), .o_horizontal_sync_out(), .o_vertical_sync_out(),
    .o_composite_data_bus());
  // Expected readback of the control register on the base variant.
  function automatic logic [7:0] exp08(input logic [7:0] w);
    exp08 = {w[7:6], 1'b0, w[4:1], 1'b1};
  endfunction
  function automatic logic exp_scv(input logic [7:0] w);
    exp_scv = !((!w[7] && w[5]) || (w[7] && w[5:4] == 2'h0));
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(negedge i_core_clk);
    req.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge i_core_clk);
    req.addr = a;
    req.rd = 1'b1;
    @(negedge i_core_clk);
    req.rd = 1'b0;
    check({7'h00, rvalid}, 8'h01);
    check(rdata, exp);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #(100 * 20000);
    n_fail++;
    report_and_stop();
  end
  initial
  begin
    repeat (2) @(negedge i_core_clk);
    i_rst_b = 1'b1;
    rd(8'h08, 8'h03);
    rd(8'h09, 8'h80);
    rd(8'h07, 8'h00);
    check({ctrl, 1'b1}, 8'h03);
    // Every standard and rate code, with random low control bits.
    for (k = 0; k < 16; k++)
    begin
      v = {k[3:0], 4'($random(seed)) & 4'hE | 4'h1};
      wr(8'h08, v);
      check({7'h00, srst}, 8'h00);
      @(negedge i_core_clk);
      check({ctrl, 1'b1}, exp08(v));
      check({7'h00, scv}, {7'h00, exp_scv(exp08(v))});
      check({ctrl_x, 1'b1}, {v[7:1], 1'b1});
      check({7'h00, scv_x}, {7'h00, exp_scv(v)});
      rd(8'h08, exp08(v));
    end
    // Blank level capture from the back porch only, first at the nominal 525-line level.
    for (k = 0; k < 3; k++)
    begin
      b = (k == 0) ? vgcr_pkg::BLANK_NOMINAL_525 : 8'($random(seed));
      @(negedge i_core_clk);
      adc = b;
      bp = 1'b1;
      @(negedge i_core_clk);
      bp = 1'b0;
      adc = ~b;
      repeat (2) @(negedge i_core_clk);
      rd(8'h06, b);
    end
    wr(8'h06, 8'h5A);
    wr(8'h07, 8'hFF);
    rd(8'h07, 8'h00);
    rd(8'h06, b);
    // Lead-lag register including the alignment code.
    for (k = 0; k < 4; k++)
    begin
      v = (k == 0) ? vgcr_pkg::OFFSET_ALIGN_CODE : 8'($random(seed));
      wr(8'h09, v);
      check(offs, v);
      rd(8'h09, v);
    end
    // Genlock path: reference data only during sync, unless suppressed.
    for (k = 0; k < 32; k++)
    begin
      if (k == 0)
        wr(8'h08, 8'h03);
      if (k == 16)
        wr(8'h08, 8'h07);
      @(negedge i_core_clk);
      {lhs, lvs, vid, grd} = 18'($random(seed));
      @(negedge i_core_clk);
      check({6'h00, hs, vs}, {6'h00, lhs, lvs});
      check(bus, (k < 16 && lhs) ? grd : vid);
    end
    lhs = 1'b0;
    // Free run: hsync from the local down-counter, two whole lines.
    wr(8'h08, 8'h0B);
    repeat (3) @(negedge i_core_clk);
    cnt = 0;
    repeat (40)
    begin
      @(negedge i_core_clk);
      cnt += hs;
    end
    check(cnt[7:0], 8'h08);
    // Soft reset keeps control and lead-lag values, clears measurement.
    @(negedge i_core_clk);
    adc = 8'h40;
    bp = 1'b1;
    @(negedge i_core_clk);
    bp = 1'b0;
    wr(8'h08, 8'h92);
    check({7'h00, srst}, 8'h01);
    @(negedge i_core_clk);
    check({7'h00, srst}, 8'h00);
    check({ctrl, 1'b1}, 8'h93);
    rd(8'h06, 8'h00);
    rd(8'h08, 8'h93);
    check(offs, v);
    report_and_stop();
  end
endmodule
`default_nettype wire
